/* src/pir_map.svh */
// constants of the peripheral interrupt router: offsets, field layout, reset values
// assumes a 32-bit register port with one word per index, byte address = 4 * index
// How it works
// - every peripheral request goes to at most one of the seven prioritized core inputs; codes above 6 select none.
// - software may change the core input of any source, which changes its priority; reset mapping holds until then.
// - a 4-bit code per source selects the core input, code n picking general-purpose input 7+n for n 0..6.
// - assignment register k covers IDs 8k..8k+7, mask and status word 0 covers IDs 0-31, word 1 IDs 32-55.
// - after reset IDs 0 to 13 use code 0, ID 11 being reserved.
// - after reset IDs 14-15 use code 1 and IDs 16-19 use code 2.
// - after reset IDs 20 to 25 use code 3.
// - after reset IDs 26 to 31 use code 4.
// - after reset IDs 32 to 41 use code 5.
// - after reset IDs 42 to 46 use code 6.
// - after reset IDs 47-50 use code 0 and IDs 51-55 use code 3, with 49 and 50 reserved.
// - a set mask bit lets its source reach the core input, a clear bit blocks it.
// - a status bit reads one while its peripheral asserts the request, zero otherwise; reserved IDs 11, 49, 50 always read zero.
// - a set wake-enable bit lets that source's request wake the idled core.
// - the core's pending bits serve as acknowledgement of forwarded requests.
`ifndef PIR_MAP_SVH
`define PIR_MAP_SVH

// register indices (byte address = 4 * index)
`define PIR_IDX_ASSIGN0     6'h00
`define PIR_IDX_MASK0       6'h07
`define PIR_IDX_MASK1       6'h08
`define PIR_IDX_STATUS0     6'h09
`define PIR_IDX_STATUS1     6'h0a
`define PIR_IDX_WAKE0       6'h0b
`define PIR_IDX_WAKE1       6'h0c
`define PIR_IDX_ACK_STAT    6'h0d
`define PIR_IDX_ACK_MASK    6'h0e
`define PIR_NUM_ASSIGN      7
`define PIR_CODE_BITS       4

// reset values of the seven assignment registers, nibble i is source 8k+i
`define PIR_RST_ASSIGN0     32'h00000000
`define PIR_RST_ASSIGN1     32'h11000000
`define PIR_RST_ASSIGN2     32'h33332222
`define PIR_RST_ASSIGN3     32'h44444433
`define PIR_RST_ASSIGN4     32'h55555555
`define PIR_RST_ASSIGN5     32'h06666655
`define PIR_RST_ASSIGN6     32'h33333000
`define PIR_RST_MASK        32'h00000000
`define PIR_RST_WAKE        32'h00000000

// reserved source IDs 11, 49, 50 as a 56-bit pattern
`define PIR_RESERVED_IDS    56'h06000000000800
`define PIR_CODE_LAST       4'h6
`define PIR_INVALID_CODE    4'hf

`endif

/* src/pir_pkg.sv */
// types of the peripheral interrupt router
// assumes pir_map.svh holds all numeric constants
package pir_pkg;
   typedef struct packed {
      logic [5:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pir_bus_req_type;

   typedef logic [3:0] pir_code_type;
endpackage

/* src/pir_route_lane.sv */
// one source lane: decodes its assignment code to a one-hot core input select
// assumes codes above 6 select no input
module pir_route_lane
   import pir_pkg::*;
(
   input  wire logic         req_i,
   input  wire logic         mask_i,
   input  wire logic         reserved_i,
   input  pir_pkg::pir_code_type code_i,
   output logic [6:0]        sel_o
);
   logic live;

   // masked or reserved sources never drive
   assign live = req_i & mask_i & ~reserved_i;

   // one-hot: code n lands on input 7+n (bit n)
   genvar g;
   generate
      for (g = 0; g < 7; g++)
      begin : g_sel
         assign sel_o[g] = live & (code_i == 4'(g));
      end
   endgenerate
endmodule // pir_route_lane

/* src/pir_router.sv */
// peripheral interrupt router top: register port, routing, wake, ack status
// assumes synchronous requests and a plain one-cycle register port
`include "pir_map.svh"
module pir_router
   import pir_pkg::*;
#(
   parameter int NSRC = 56
)
(
   input  wire logic                clk_sys_i,
   input  wire logic                arst_n_i,
   input  pir_pkg::pir_bus_req_type bus_i,
   output logic [31:0]              rdata_o,
   input  wire logic [NSRC-1:0]     periph_irq_i,
   input  wire logic [6:0]          core_pending_bits_i,
   input  wire logic                core_idle_i,
   output logic [6:0]               gp_input_o,
   output logic                     wake_o,
   output logic                     irq_o
);
   logic              rst_n;
   logic [31:0]       assign_r [`PIR_NUM_ASSIGN];
   logic [63:0]       mask_r;
   logic [63:0]       wake_r;
   logic [63:0]       raw_status;
   logic [NSRC-1:0]   live_req;
   logic [6:0]        sel [NSRC];
   logic [6:0]        gp_nxt;
   logic [6:0]        gp_r;
   logic [6:0]        pend_d_r;
   logic [6:0]        ack_stat_r;
   logic [6:0]        ack_mask_r;
   logic [6:0]        ack_rise;
   logic [31:0]       rdata_nxt;
   logic [31:0]       rdata_r;
   logic              wake_r_o;
   logic [55:0]       reserved_ids;

   pir_rst_sync u_rst
   (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .rst_n_o   (rst_n)
   );

   assign reserved_ids = `PIR_RESERVED_IDS;

   // write decode
   wire wr_mask0 = bus_i.wr && bus_i.addr == `PIR_IDX_MASK0;
   wire wr_mask1 = bus_i.wr && bus_i.addr == `PIR_IDX_MASK1;
   wire wr_wake0 = bus_i.wr && bus_i.addr == `PIR_IDX_WAKE0;
   wire wr_wake1 = bus_i.wr && bus_i.addr == `PIR_IDX_WAKE1;
   wire wr_ackst = bus_i.wr && bus_i.addr == `PIR_IDX_ACK_STAT;
   wire wr_ackmk = bus_i.wr && bus_i.addr == `PIR_IDX_ACK_MASK;

   // assignment registers, one per eight sources, reset mapping per table
   genvar k;
   generate
      for (k = 0; k < `PIR_NUM_ASSIGN; k++)
      begin : g_assign
         localparam logic [31:0] RST_VAL =
            (k == 0) ? `PIR_RST_ASSIGN0 : (k == 1) ? `PIR_RST_ASSIGN1 :
            (k == 2) ? `PIR_RST_ASSIGN2 : (k == 3) ? `PIR_RST_ASSIGN3 :
            (k == 4) ? `PIR_RST_ASSIGN4 : (k == 5) ? `PIR_RST_ASSIGN5 :
            `PIR_RST_ASSIGN6;
         wire wr_here = bus_i.wr && bus_i.addr == (`PIR_IDX_ASSIGN0 + 6'(k));
         always_ff @(posedge clk_sys_i or negedge rst_n)
         begin
            if (!rst_n)
               assign_r[k] <= RST_VAL;
            else if (wr_here)
               assign_r[k] <= bus_i.wdata;
         end
      end
   endgenerate

   // mask and wake words, upper word keeps only 24 bits
   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mask_r <= {`PIR_RST_MASK, `PIR_RST_MASK};
         wake_r <= {`PIR_RST_WAKE, `PIR_RST_WAKE};
      end
      else
      begin
         if (wr_mask0) mask_r[31:0]  <= bus_i.wdata;
         if (wr_mask1) mask_r[63:32] <= {8'h00, bus_i.wdata[23:0]};
         if (wr_wake0) wake_r[31:0]  <= bus_i.wdata;
         if (wr_wake1) wake_r[63:32] <= {8'h00, bus_i.wdata[23:0]};
      end
   end

   // per-source routing lanes
   genvar s;
   generate
      for (s = 0; s < NSRC; s++)
      begin : g_lane
         pir_route_lane u_lane
         (
            .req_i      (periph_irq_i[s]),
            .mask_i     (mask_r[s]),
            .reserved_i (reserved_ids[s]),
            .code_i     (assign_r[s/8][(s%8)*4 +: 4]),
            .sel_o      (sel[s])
         );
         assign live_req[s]   = periph_irq_i[s] & ~reserved_ids[s];
         assign raw_status[s] = live_req[s];
      end
      for (s = NSRC; s < 64; s++)
      begin : g_pad
         assign raw_status[s] = 1'b0;
      end
   endgenerate

   // OR of every lane onto each core input
   always_comb
   begin
      gp_nxt = 7'h00;
      for (int i = 0; i < NSRC; i++)
         gp_nxt = gp_nxt | sel[i];
   end

   // wake request: any enabled live source while core is idle
   wire wake_nxt = core_idle_i && |(live_req & wake_r[NSRC-1:0]);

   // pending-bit rise means the core took an input: sticky ack status
   assign ack_rise = core_pending_bits_i & ~pend_d_r;

   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gp_r       <= 7'h00;
         pend_d_r   <= 7'h00;
         ack_stat_r <= 7'h00;
         ack_mask_r <= 7'h00;
         wake_r_o   <= 1'b0;
      end
      else
      begin
         gp_r     <= gp_nxt;
         pend_d_r <= core_pending_bits_i;
         wake_r_o <= wake_nxt;
         // set wins over write-one-to-clear
         ack_stat_r <= (ack_stat_r & ~(wr_ackst ? bus_i.wdata[6:0] : 7'h00)) | ack_rise;
         if (wr_ackmk) ack_mask_r <= bus_i.wdata[6:0];
      end
   end

   // read mux, unmapped reads zero
   always_comb
   begin
      rdata_nxt = 32'h00000000;
      if (bus_i.addr < `PIR_IDX_MASK0)
         rdata_nxt = assign_r[3'(bus_i.addr)];
      else
      begin
         case (bus_i.addr)
            `PIR_IDX_MASK0:    rdata_nxt = mask_r[31:0];
            `PIR_IDX_MASK1:    rdata_nxt = mask_r[63:32];
            `PIR_IDX_STATUS0:  rdata_nxt = raw_status[31:0];
            `PIR_IDX_STATUS1:  rdata_nxt = raw_status[63:32];
            `PIR_IDX_WAKE0:    rdata_nxt = wake_r[31:0];
            `PIR_IDX_WAKE1:    rdata_nxt = wake_r[63:32];
            `PIR_IDX_ACK_STAT: rdata_nxt = {25'h0000000, ack_stat_r};
            `PIR_IDX_ACK_MASK: rdata_nxt = {25'h0000000, ack_mask_r};
            default:           rdata_nxt = 32'h00000000;
         endcase
      end
   end

   // read data appear one cycle after the strobe, only then
   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
         rdata_r <= 32'h00000000;
      else
         rdata_r <= bus_i.rd ? rdata_nxt : 32'h00000000;
   end

   assign rdata_o    = rdata_r;
   assign gp_input_o = gp_r;
   assign wake_o     = wake_r_o;
   assign irq_o      = |(ack_stat_r & ack_mask_r);
endmodule // pir_router

/* src/pir_rst_sync.sv */
// reset synchroniser: asynchronous assert, release through two flip-flops
// assumes clk_sys_i runs freely
module pir_rst_sync
(
   input  wire logic clk_sys_i,
   input  wire logic arst_n_i,
   output logic      rst_n_o
);
   logic meta_r;
   logic hold_r;

   // first stage read only by second
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         meta_r <= 1'b0;
         hold_r <= 1'b0;
      end
      else
      begin
         meta_r <= 1'b1;
         hold_r <= meta_r;
      end
   end

   assign rst_n_o = hold_r;
endmodule // pir_rst_sync

/* verif/pir_core_model.sv */
// core event controller model: pending bits follow forwarded inputs
// assumes gp inputs are registered levels on the same clock
module pir_core_model #(
   parameter int DLY = 3
)
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [6:0] gp_i,
   output logic [6:0]      pending_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DLY*7-1:0] sh_r;
   // pending follows its input DLY cycles later, on the rise and on the drop alike
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         sh_r <= '0;
      else
         sh_r <= {sh_r[DLY*7-8:0], gp_i};
   end
   assign pending_o = sh_r[DLY*7-1 -: 7];
endmodule // pir_core_model

/* verif/pir_router_assertions.sv */
// port checker of the interrupt router
// assumes binding into pir_router, one clock domain
`include "pir_map.svh"
module pir_router_assertions
   import pir_pkg::*;
#(
   parameter int NSRC = 56
)
(
   input wire logic                clk_sys_i,
   input wire logic                arst_n_i,
   input pir_pkg::pir_bus_req_type bus_i,
   input wire logic [31:0]         rdata_o,
   input wire logic [NSRC-1:0]     periph_irq_i,
   input wire logic [6:0]          core_pending_bits_i,
   input wire logic                core_idle_i,
   input wire logic [6:0]          gp_input_o,
   input wire logic                wake_o,
   input wire logic                irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [55:0] RES = `PIR_RESERVED_IDS;
   // live requests with reserved lines removed
   wire logic [55:0] live = 56'(periph_irq_i) & ~RES;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   AST_RD_IDLE:
      assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0) else $error("stray rdata");
   AST_STAT0:
      assert property ($past(bus_i.rd) && $past(bus_i.addr) == `PIR_IDX_STATUS0
         |-> rdata_o == $past(live[31:0])) else $error("status0 bad");
   AST_STAT1:
      assert property ($past(bus_i.rd) && $past(bus_i.addr) == `PIR_IDX_STATUS1
         |-> rdata_o == {8'h00, $past(live[55:32])}) else $error("status1 bad");
   AST_HI_ZERO:
      assert property ($past(bus_i.rd) && ($past(bus_i.addr) == `PIR_IDX_MASK1
         || $past(bus_i.addr) == `PIR_IDX_WAKE1) |-> rdata_o[31:24] == 8'h00)
         else $error("word1 top bits set");
   AST_UNMAPPED:
      assert property ($past(bus_i.rd) && $past(bus_i.addr) > `PIR_IDX_ACK_MASK
         |-> rdata_o == 32'h0) else $error("unmapped read nonzero");
   AST_GP_RES:
      assert property ($past(live) == 56'h0 |-> gp_input_o == 7'h00) else $error("gp without request");
   AST_WAKE:
      assert property (wake_o |-> $past(core_idle_i) && $past(live) != 56'h0)
         else $error("wake without cause");
   AST_GP_HOLD:
      assert property ($past(periph_irq_i) == $past(periph_irq_i, 2) && !$past(bus_i.wr, 2)
         |-> $stable(gp_input_o)) else $error("gp moved");
endmodule // pir_router_assertions

/* verif/pir_router_tb_top.sv */
// self-checking bench of the interrupt router
// assumes src on the include path
`include "pir_map.svh"
module pir_router_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pir_pkg::*;
   localparam logic [55:0] RES = `PIR_RESERVED_IDS;
   logic            clk_sys_i = 1'b0;
   logic            arst_n_i = 1'b0;
   logic            core_idle_i = 1'b0;
   logic            irq_o, wake_o;
   pir_bus_req_type bus_i = '0;
   logic [55:0]     periph_irq_i = '0, msk = '0, wk = '0;
   logic [31:0]     rdata_o;
   logic [6:0]      gp_input_o, pend;
   int              code [56];
   int              fail_count = 0, total_checks = 0;

   always #50 clk_sys_i = ~clk_sys_i;

   pir_router #(.NSRC(56)) dut_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .bus_i(bus_i),
      .rdata_o(rdata_o), .periph_irq_i(periph_irq_i), .core_pending_bits_i(pend),
      .core_idle_i(core_idle_i), .gp_input_o(gp_input_o), .wake_o(wake_o), .irq_o(irq_o));
   pir_core_model core_u (.clk_i(clk_sys_i), .rst_n_i(arst_n_i), .gp_i(gp_input_o), .pending_o(pend));

   task automatic results();
      $display("checks %0d failures %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
         fail_count++;
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      bus_i.addr <= a;
      bus_i.wdata <= d;
      bus_i.wr <= 1'b1;
      @(posedge clk_sys_i);
      bus_i.wr <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      @(posedge clk_sys_i);
      bus_i.addr <= a;
      bus_i.rd <= 1'b1;
      @(posedge clk_sys_i);
      bus_i.rd <= 1'b0;
      #1 chk("rdata", rdata_o, exp);
   endtask

   // steering after reset, per source ID
   function automatic int rst_code(int i);
      if (i < 14 || (i > 46 && i < 51)) return 0;
      if (i < 16) return 1;
      if (i < 20) return 2;
      if (i < 26 || i > 50) return 3;
      if (i < 32) return 4;
      return (i < 42) ? 5 : 6;
   endfunction

   // expected core inputs from the model state
   function automatic logic [6:0] exp_gp(logic [55:0] v);
      logic [6:0] e = '0;
      for (int i = 0; i < 56; i++)
         if (v[i] && msk[i] && !RES[i] && code[i] < 7) e[code[i]] = 1'b1;
      return e;
   endfunction

   // hang guard
   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      fail_count++;
      results();
   end

   // main sequence
   initial
   begin
      int k, n;
      logic [31:0] d;
      logic [55:0] v;
      void'($urandom(1622));
      for (k = 0; k < 56; k++) code[k] = rst_code(k);
      repeat (4) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      for (k = 0; k < 7; k++)
      begin
         for (n = 0; n < 8; n++) d[4*n +: 4] = code[8*k+n][3:0];
         rd(k[5:0], d);
      end
      rd(`PIR_IDX_MASK0, 32'h0);
      rd(6'h3f, 32'h0);
      $display("test reset_map done");
      d = $urandom;
      wr(`PIR_IDX_WAKE0, d);
      wk[31:0] = d;
      d = $urandom;
      wr(`PIR_IDX_WAKE1, d);
      wk[55:32] = d[23:0];
      rd(`PIR_IDX_WAKE0, wk[31:0]);
      rd(`PIR_IDX_WAKE1, {8'h00, wk[55:32]});
      for (n = 0; n < 60; n++)
      begin
         k = $urandom_range(6);
         d = $urandom;
         wr(k[5:0], d);
         rd(k[5:0], d);
         for (int i = 0; i < 8; i++) code[8*k+i] = d[4*i +: 4];
         d = $urandom;
         wr(`PIR_IDX_MASK0, d);
         msk[31:0] = d;
         d = $urandom;
         wr(`PIR_IDX_MASK1, d);
         msk[55:32] = d[23:0];
         rd(`PIR_IDX_MASK0, msk[31:0]);
         v = 56'({$urandom, $urandom} & {$urandom, $urandom});
         @(posedge clk_sys_i);
         periph_irq_i <= v;
         core_idle_i <= n[1];
         @(posedge clk_sys_i);
         #1 chk("gp", 32'(gp_input_o), 32'(exp_gp(v)));
         chk("wake", 32'(wake_o), 32'(n[1] & |(v & wk & ~RES)));
         rd(`PIR_IDX_STATUS0, v[31:0] & ~RES[31:0]);
         rd(`PIR_IDX_STATUS1, {8'h00, v[55:32] & ~RES[55:32]});
         rd(`PIR_IDX_MASK1, {8'h00, msk[55:32]});
      end
      $display("test random_route done");
      @(posedge clk_sys_i);
      periph_irq_i <= '0;
      wr(`PIR_IDX_ACK_MASK, 32'h0);
      repeat (8) @(posedge clk_sys_i);
      wr(`PIR_IDX_ACK_STAT, 32'h7f);
      rd(`PIR_IDX_ACK_STAT, 32'h0);
      wr(6'h02, 32'h0005_0000);
      wr(`PIR_IDX_MASK0, 32'h0010_0000);
      @(posedge clk_sys_i);
      periph_irq_i <= 56'(1) << 20;
      n = 0;
      while (pend !== 7'h20 && n < 20)
      begin
         @(posedge clk_sys_i);
         n++;
      end
      chk("pending", 32'(n < 20), 32'h1);
      // a timed-out wait skips the rest and goes straight to the verdict
      if (n < 20)
      begin
         rd(`PIR_IDX_ACK_STAT, 32'h20);
         chk("irq masked", 32'(irq_o), 32'h0);
         wr(`PIR_IDX_ACK_MASK, 32'h20);
         #1 chk("irq set", 32'(irq_o), 32'h1);
         rd(`PIR_IDX_ACK_MASK, 32'h20);
         wr(`PIR_IDX_ACK_STAT, 32'h20);
         #1 chk("irq clr", 32'(irq_o), 32'h0);
         $display("test ack done");
      end
      results();
   end
endmodule // pir_router_tb_top

bind pir_router pir_router_assertions #(.NSRC(NSRC)) chk_u (.clk_sys_i(clk_sys_i),
   .arst_n_i(arst_n_i), .bus_i(bus_i), .rdata_o(rdata_o), .periph_irq_i(periph_irq_i),
   .core_pending_bits_i(core_pending_bits_i), .core_idle_i(core_idle_i),
   .gp_input_o(gp_input_o), .wake_o(wake_o), .irq_o(irq_o));
